// ===== include/uii_pkg.sv
// Package for the serial-port interrupt identification block.
// Holds register addresses, field positions, reset values, carriers and shared decoders.
// Assumes a 32-bit classic Wishbone bus and a receive clock tick from the baud generator.
package uii_pkg;

   // ------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------
   localparam logic [31:0] UII_ADR_DATA = 32'hE004_5000; // Rx buffer read / Tx holding write
   localparam logic [31:0] UII_ADR_IER = 32'hE004_5004; // Interrupt enable
   localparam logic [31:0] UII_ADR_IIR = 32'hE004_5008; // Source id read / FIFO control write
   localparam logic [31:0] UII_ADR_LCR = 32'hE004_500C; // Line control (word length)
   localparam logic [31:0] UII_ADR_LSR = 32'hE004_5014; // Line status read
   localparam logic [31:0] UII_ADR_ACR = 32'hE004_5020; // Auto-baud flag clear

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int UII_IER_RDA = 0; // Rx data / time-out enable
   localparam int UII_IER_THR = 1; // Tx empty enable
   localparam int UII_IER_RLS = 2; // Line error enable
   localparam int UII_IER_ABE = 8; // Auto-baud done enable
   localparam int UII_IER_ABT = 9; // Auto-baud time-out enable
   localparam int UII_FCR_FEN = 0; // FIFO enable
   localparam int UII_FCR_TRG = 6; // Trigger level, two bits
   localparam int UII_ACR_ABE_CLR = 8; // Clears auto-baud done flag
   localparam int UII_ACR_ABT_CLR = 9; // Clears auto-baud time-out flag

   // ------------------------------------------------------------
   // Codes and reset values
   // ------------------------------------------------------------
   localparam logic [2:0] UII_ID_NONE = 3'h0;
   localparam logic [2:0] UII_ID_RLS = 3'h3; // Line error
   localparam logic [2:0] UII_ID_RDA = 3'h2; // Rx data available
   localparam logic [2:0] UII_ID_CTI = 3'h6; // Character time-out
   localparam logic [2:0] UII_ID_THR = 3'h1; // Tx empty
   localparam logic [9:0] UII_IER_RST = 10'h000;
   localparam logic [1:0] UII_TRG_RST = 2'h0;
   localparam logic [1:0] UII_WL_RST = 2'h0;
   localparam int UII_BIT_TICKS = 16; // Receive clocks per bit
   localparam int UII_TMO_MIN_W = 10; // Least timer width for the longest time-out

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [31:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } uii_wb_req_type;

   typedef struct packed {
      logic [3:0] err_evt; // Overrun, parity, framing, break pulses (bits 0..3)
      logic wr; // Character written into the Rx FIFO
      logic [4:0] count; // Characters held in the Rx FIFO
      logic [7:0] data; // Oldest character in the Rx FIFO
   } uii_rx_type;

   // Trigger level code to character count
   function automatic logic [4:0] uii_trig_chars(input logic [1:0] code);
      case (code)
         2'h0: uii_trig_chars = 5'h01;
         2'h1: uii_trig_chars = 5'h04;
         2'h2: uii_trig_chars = 5'h08;
         default: uii_trig_chars = 5'h0E;
      endcase
   endfunction

endpackage

// ===== hdl/uii_irq_ident.sv
// Interrupt ranking and identification for an asynchronous serial port.
// Assumes the FIFOs, receiver and transmitter live outside and report counts and event pulses
// synchronous to SYS_CLK; RCLK_TICK is one pulse per receive clock (16 per bit).
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/100ps

// Functional notes
// - Bit 0 low while error, data, timeout or empty pending
// - Ids: error 011, data 010, timeout 110, empty 001
// - Nothing pending gives id field zero
// - Bits 7:6 mirror FIFO enable
// - Bit 8 shows enabled auto-baud done
// - Bit 9 shows enabled auto-baud time-out
// - Auto-baud flags cleared only by clear bits
// - Id read frozen; new events shown next read
// - Line error highest, set by any error
// - Error cause visible in line status 4:1
// - Line status read clears line error
// - Data second level, timeout third level
// - With FIFO enabled, data available follows fill versus trigger
// - Timeout after idle with characters held
// - Timeout length from word length and fill
// - Any Rx FIFO activity clears timeout
// - Tx empty lowest, raised when FIFO empty
// - Delay empty by char minus stop
// - No delay after FIFO held two characters
// - Holding write or id read showing empty clears empty
// - Enable bit 0 gates data and timeout
module uii_irq_ident
   import uii_pkg::*;
#(
   parameter int TMO_W = 11, // Width of the character time-out timer
   parameter int DLY_W = 8 // Width of the start-up delay timer
)(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire uii_wb_req_type WB_REQ,
   output logic WB_ACK_O,
   output logic [31:0] WB_DAT_O,
   input wire uii_rx_type RX_STAT,
   input wire logic [4:0] TX_COUNT,
   input wire logic RCLK_TICK,
   input wire logic AB_DONE_EVT,
   input wire logic AB_TMO_EVT,
   output logic IRQ_REQ,
   output logic TX_WR_STB,
   output logic [7:0] TX_WR_DATA,
   output logic RX_RD_STB,
   output logic FIFO_EN
);

   // ------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------
   generate
      if (TMO_W < UII_TMO_MIN_W || TMO_W > 16) begin : g_bad_tmo
         $error("TMO_W must be 10 to 16");
      end
      if (DLY_W < 8 || DLY_W > 16) begin : g_bad_dly
         $error("DLY_W must be 8 to 16");
      end
   endgenerate

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic ack; // Bus answer
      logic [31:0] dat; // Bus read data
      logic was_iir; // Answer belongs to an id read
      logic [9:0] ier; // Interrupt enables
      logic fen; // FIFO enable
      logic [1:0] trig; // Trigger level code
      logic [1:0] wlen; // Word length code
      logic [3:0] lsr_err; // Sticky line errors
      logic char_timeout_irq; // Time-out flag
      logic [TMO_W-1:0] tmo_cnt; // Idle receive clocks
      logic tx_empty_irq; // Tx empty flag
      logic two_seen; // Tx FIFO held two characters
      logic empty_prev; // Tx FIFO empty last cycle
      logic dly_run; // Start-up delay running
      logic [DLY_W-1:0] dly_cnt; // Start-up delay count
      logic ab_done; // Auto-baud done flag
      logic ab_tmo; // Auto-baud time-out flag
      logic irq; // Request line
      logic tx_stb; // Tx holding write pulse
      logic [7:0] tx_data; // Tx holding write data
      logic rx_stb; // Rx buffer read pulse
   } uii_state_type;

   uii_state_type s_q; // Registered state
   uii_state_type s_d; // Next state

   // ------------------------------------------------------------
   // Source evaluation from registered state and the live Rx FIFO count
   // ------------------------------------------------------------
   logic rle_pend; // Line error pending
   logic rda_pend; // Rx data available pending
   logic cti_pend; // Time-out pending
   logic thr_pend; // Tx empty pending
   logic any_pend; // Anything pending
   logic [2:0] cur_id; // Highest pending id
   logic [TMO_W-1:0] tmo_len; // Time-out length in receive clocks
   logic [DLY_W-1:0] dly_len; // Start-up delay in receive clocks

   // Priority ranking and time lengths
   always_comb begin
      int wl;
      int extra;
      int base;
      wl = 5 + int'(s_q.wlen);
      base = (wl * 7 - 2) * 8;
      extra = (int'(uii_trig_chars(s_q.trig)) - int'(RX_STAT.count)) * 8 + 1;
      if (extra < 1) begin
         extra = 1;
      end
      tmo_len = TMO_W'(base + extra);
      dly_len = DLY_W'((wl + 1) * UII_BIT_TICKS);
      rle_pend = (|s_q.lsr_err) & s_q.ier[UII_IER_RLS];
      rda_pend = s_q.fen & s_q.ier[UII_IER_RDA] &
                 (RX_STAT.count >= uii_trig_chars(s_q.trig));
      cti_pend = s_q.char_timeout_irq & s_q.ier[UII_IER_RDA];
      thr_pend = s_q.tx_empty_irq & s_q.ier[UII_IER_THR];
      any_pend = rle_pend | rda_pend | cti_pend | thr_pend;
      // Highest source first
      if (rle_pend) begin
         cur_id = UII_ID_RLS;
      end else if (rda_pend) begin
         cur_id = UII_ID_RDA;
      end else if (cti_pend) begin
         cur_id = UII_ID_CTI;
      end else if (thr_pend) begin
         cur_id = UII_ID_THR;
      end else begin
         cur_id = UII_ID_NONE;
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic take; // Request taken this cycle
      logic wr; // Taken write
      logic rd; // Taken read
      logic tx_empty; // Tx FIFO empty now
      logic rx_act; // Rx FIFO activity
      s_d = s_q;
      take = WB_REQ.cyc & WB_REQ.stb & ~s_q.ack;
      wr = take & WB_REQ.we;
      rd = take & ~WB_REQ.we;
      tx_empty = (TX_COUNT == 5'h00);
      rx_act = RX_STAT.wr | (rd & (WB_REQ.adr == UII_ADR_DATA));
      s_d.ack = take;
      s_d.was_iir = 1'b0;
      s_d.tx_stb = 1'b0;
      s_d.rx_stb = 1'b0;
      // Read data, captured once per access so the id stays frozen
      if (rd) begin
         s_d.dat = 32'h0000_0000;
         if (WB_REQ.adr == UII_ADR_IIR) begin
            s_d.was_iir = 1'b1;
            s_d.dat[0] = ~any_pend;
            s_d.dat[3:1] = cur_id;
            s_d.dat[7:6] = {2{s_q.fen}};
            s_d.dat[8] = s_q.ab_done & s_q.ier[UII_IER_ABE];
            s_d.dat[9] = s_q.ab_tmo & s_q.ier[UII_IER_ABT];
         end else if (WB_REQ.adr == UII_ADR_DATA) begin
            s_d.dat[7:0] = RX_STAT.data;
            s_d.rx_stb = 1'b1;
         end else if (WB_REQ.adr == UII_ADR_IER) begin
            s_d.dat[9:0] = s_q.ier;
         end else if (WB_REQ.adr == UII_ADR_LCR) begin
            s_d.dat[1:0] = s_q.wlen;
         end else if (WB_REQ.adr == UII_ADR_LSR) begin
            s_d.dat[0] = (RX_STAT.count != 5'h00);
            s_d.dat[4:1] = s_q.lsr_err;
            s_d.dat[5] = tx_empty;
         end else begin
            s_d.dat = 32'h0000_0000; // Unmapped reads zero
         end
      end
      // Register writes honour byte lanes
      if (wr) begin
         if (WB_REQ.adr == UII_ADR_DATA) begin
            if (WB_REQ.sel[0]) begin
               s_d.tx_stb = 1'b1;
               s_d.tx_data = WB_REQ.dat[7:0];
            end
         end else if (WB_REQ.adr == UII_ADR_IER) begin
            if (WB_REQ.sel[0]) begin
               s_d.ier[2:0] = WB_REQ.dat[2:0];
            end
            if (WB_REQ.sel[1]) begin
               s_d.ier[9:8] = WB_REQ.dat[9:8];
            end
         end else if (WB_REQ.adr == UII_ADR_IIR) begin
            if (WB_REQ.sel[0]) begin
               s_d.fen = WB_REQ.dat[UII_FCR_FEN];
               s_d.trig = WB_REQ.dat[UII_FCR_TRG+:2];
            end
         end else if (WB_REQ.adr == UII_ADR_LCR) begin
            if (WB_REQ.sel[0]) begin
               s_d.wlen = WB_REQ.dat[1:0];
            end
         end else if (WB_REQ.adr == UII_ADR_ACR) begin
            if (WB_REQ.sel[1] && WB_REQ.dat[UII_ACR_ABE_CLR]) begin
               s_d.ab_done = 1'b0;
            end
            if (WB_REQ.sel[1] && WB_REQ.dat[UII_ACR_ABT_CLR]) begin
               s_d.ab_tmo = 1'b0;
            end
         end
      end
      // Auto-baud flags: set wins over clear
      if (AB_DONE_EVT) begin
         s_d.ab_done = 1'b1;
      end
      if (AB_TMO_EVT) begin
         s_d.ab_tmo = 1'b1;
      end
      // Line errors: status read clears, new error wins
      if (rd && WB_REQ.adr == UII_ADR_LSR) begin
         s_d.lsr_err = 4'h0;
      end
      for (int i = 0; i < 4; i++) begin
         if (RX_STAT.err_evt[i]) begin
            s_d.lsr_err[i] = 1'b1;
         end
      end
      // Character time-out timer
      if (rx_act || RX_STAT.count == 5'h00) begin
         s_d.tmo_cnt = '0;
         s_d.char_timeout_irq = 1'b0;
      end else if (RCLK_TICK && !s_q.char_timeout_irq) begin
         s_d.tmo_cnt = s_q.tmo_cnt + 1'b1;
         if (s_q.tmo_cnt + 1'b1 >= tmo_len) begin
            s_d.char_timeout_irq = 1'b1;
         end
      end
      // Tx empty: clears first, so a set in the same cycle wins
      s_d.empty_prev = tx_empty;
      if (wr && WB_REQ.adr == UII_ADR_DATA && WB_REQ.sel[0]) begin
         s_d.tx_empty_irq = 1'b0;
      end
      if (rd && WB_REQ.adr == UII_ADR_IIR && cur_id == UII_ID_THR) begin
         s_d.tx_empty_irq = 1'b0;
      end
      if (TX_COUNT >= 5'h02) begin
         s_d.two_seen = 1'b1;
      end
      if (!tx_empty) begin
         s_d.dly_run = 1'b0;
      end else if (!s_q.empty_prev) begin
         // New empty event
         if (s_q.two_seen) begin
            s_d.tx_empty_irq = 1'b1;
            s_d.two_seen = 1'b0;
         end else begin
            s_d.dly_run = 1'b1;
            s_d.dly_cnt = '0;
         end
      end else if (s_q.dly_run && RCLK_TICK) begin
         s_d.dly_cnt = s_q.dly_cnt + 1'b1;
         if (s_q.dly_cnt + 1'b1 >= dly_len) begin
            s_d.tx_empty_irq = 1'b1;
            s_d.dly_run = 1'b0;
            s_d.two_seen = 1'b0;
         end
      end
      s_d.irq = any_pend;
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         s_q <= '0;
         s_q.ier <= UII_IER_RST;
         s_q.trig <= UII_TRG_RST;
         s_q.wlen <= UII_WL_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign WB_ACK_O = s_q.ack;
   assign WB_DAT_O = s_q.dat;
   assign IRQ_REQ = s_q.irq;
   assign TX_WR_STB = s_q.tx_stb;
   assign TX_WR_DATA = s_q.tx_data;
   assign RX_RD_STB = s_q.rx_stb;
   assign FIFO_EN = s_q.fen;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_irq_follows;
      @(posedge SYS_CLK) disable iff (!RST_N)
      any_pend |=> IRQ_REQ;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("request line missed pending source");

   property p_id_zero;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (WB_ACK_O && s_q.was_iir && WB_DAT_O[0]) |-> (WB_DAT_O[3:1] == 3'h0);
   endproperty
   a_id_zero: assert property (p_id_zero) else $error("id nonzero with nothing pending");

   property p_fen_mirror;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (WB_ACK_O && s_q.was_iir) |-> (WB_DAT_O[7:6] == {2{$past(s_q.fen)}});
   endproperty
   a_fen_mirror: assert property (p_fen_mirror) else $error("fifo enable not mirrored");

   property p_rle_top;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (WB_ACK_O && s_q.was_iir && $past(rle_pend)) |-> (WB_DAT_O[3:0] == 4'h6);
   endproperty
   a_rle_top: assert property (p_rle_top) else $error("line error not reported first");

   property p_lsr_clear;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (WB_REQ.cyc && WB_REQ.stb && !WB_REQ.we && !s_q.ack && WB_REQ.adr == UII_ADR_LSR &&
       RX_STAT.err_evt == 4'h0) |=> (s_q.lsr_err == 4'h0) && !rle_pend;
   endproperty
   a_lsr_clear: assert property (p_lsr_clear) else $error("status read left line error");

   property p_cti_act;
      @(posedge SYS_CLK) disable iff (!RST_N)
      RX_STAT.wr |=> !s_q.char_timeout_irq;
   endproperty
   a_cti_act: assert property (p_cti_act) else $error("fifo activity kept time-out");

   property p_thr_wr;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (WB_REQ.cyc && WB_REQ.stb && WB_REQ.we && !s_q.ack && WB_REQ.sel[0] &&
       WB_REQ.adr == UII_ADR_DATA && !(TX_COUNT == 5'h00 && !s_q.empty_prev && s_q.two_seen) &&
       !(s_q.dly_run && RCLK_TICK)) |=> !s_q.tx_empty_irq;
   endproperty
   a_thr_wr: assert property (p_thr_wr) else $error("holding write left tx empty");

   property p_ab_hold;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (s_q.ab_done && !(WB_REQ.cyc && WB_REQ.stb && WB_REQ.we && WB_REQ.adr == UII_ADR_ACR)) |=> s_q.ab_done;
   endproperty
   a_ab_hold: assert property (p_ab_hold) else $error("auto-baud flag lost without clear");

   property p_thr_fast;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (TX_COUNT == 5'h00 && !s_q.empty_prev && s_q.two_seen) |=> s_q.tx_empty_irq;
   endproperty
   a_thr_fast: assert property (p_thr_fast) else $error("tx empty delayed after two characters");

   // Pending bit of an id read reflects the state at the taking edge
   property p_id_pend;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (WB_ACK_O && s_q.was_iir) |-> (WB_DAT_O[0] == !$past(any_pend));
   endproperty
   a_id_pend: assert property (p_id_pend) else $error("pending bit wrong in id read");

   // An error arriving at the taking edge waits for the next id read
   property p_id_frozen;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (WB_REQ.cyc && WB_REQ.stb && !WB_REQ.we && !s_q.ack && WB_REQ.adr == UII_ADR_IIR &&
       RX_STAT.err_evt != 4'h0 && !rle_pend) |=> (WB_DAT_O[3:1] != UII_ID_RLS) && (s_q.lsr_err != 4'h0);
   endproperty
   a_id_frozen: assert property (p_id_frozen) else $error("id read not frozen against new error");

   // An id read that reports tx empty clears it unless a new set lands
   property p_thr_id_clr;
      @(posedge SYS_CLK) disable iff (!RST_N)
      (WB_REQ.cyc && WB_REQ.stb && !WB_REQ.we && !s_q.ack && WB_REQ.adr == UII_ADR_IIR &&
       cur_id == UII_ID_THR && !(TX_COUNT == 5'h00 && !s_q.empty_prev) &&
       !(s_q.dly_run && RCLK_TICK)) |=> !s_q.tx_empty_irq;
   endproperty
   a_thr_id_clr: assert property (p_thr_id_clr) else $error("id read left tx empty");

endmodule

// ===== dv/uii_cpu_model.sv
// Processor side model: the interrupt input of the core and its service routine entry.
// Assumes IRQ_REQ is a registered level from the identification block, on SYS_CLK.
`timescale 1ns/100ps

module uii_cpu_model
   import uii_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic IRQ_REQ,
   output int irq_entries
);
   // ---------------------------------------------
   // Interrupt entry counter
   // ---------------------------------------------
   logic irq_last_q; // Line level one cycle back

   // Each rising request enters the service routine once
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         irq_last_q <= 1'b0;
         irq_entries <= 0;
      end else begin
         irq_last_q <= IRQ_REQ;
         if (IRQ_REQ === 1'b1 && irq_last_q === 1'b0) begin
            irq_entries <= irq_entries + 1;
         end
      end
   end
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the interrupt identification block.
// Assumes a 50 MHz clock, classic Wishbone single cycles, ack one cycle after taking.
`timescale 1ns/100ps

module tb_top
   import uii_pkg::*;
;
   // ---------------------------------------------
   // Stimulus and observed signals
   // ---------------------------------------------
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   uii_wb_req_type req = '0;
   uii_rx_type rx = '0;
   logic [4:0] tx_count = 5'h00;
   logic tick = 1'b0;
   logic ab_done = 1'b0;
   logic ab_tmo = 1'b0;
   logic ack, irq, tx_stb, rx_stb, fen;
   logic [31:0] rdat;
   logic [7:0] tx_dat;
   int fail_count = 0;
   int compares = 0;
   int entries;
   logic stb_seen; // Holding strobe seen at ack
   logic [7:0] dat_seen; // Holding data seen at ack
   logic rd_seen; // Buffer read strobe seen at ack
   logic [31:0] q;

   // Clock at 20 ns period
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end

   uii_irq_ident i_uii_irq_ident (.SYS_CLK(sys_clk), .RST_N(rst_n), .WB_REQ(req), .WB_ACK_O(ack),
      .WB_DAT_O(rdat), .RX_STAT(rx), .TX_COUNT(tx_count), .RCLK_TICK(tick), .AB_DONE_EVT(ab_done),
      .AB_TMO_EVT(ab_tmo), .IRQ_REQ(irq), .TX_WR_STB(tx_stb), .TX_WR_DATA(tx_dat), .RX_RD_STB(rx_stb),
      .FIFO_EN(fen));

   uii_cpu_model i_uii_cpu_model (.SYS_CLK(sys_clk), .RST_N(rst_n), .IRQ_REQ(irq), .irq_entries(entries));

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask

   // One classic cycle; waits for ack however long it takes
   task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge sys_clk);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1);
      r = rdat;
      stb_seen = tx_stb;
      dat_seen = tx_dat;
      rd_seen = rx_stb;
      req <= '0;
      // Ack stands in the cycle after the taking edge
      chk("ack_latency", 32'd2, n);
   endtask

   // Waits up to lim cycles for the request line to reach lvl
   task automatic wait_irq(input logic lvl, input int lim, output int n);
      n = 0;
      while (irq !== lvl && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset_and_rx_data;
      wb(0, UII_ADR_IIR, 0, q);
      chk("id_reset", 32'h0000_0001, q);
      wb(0, 32'hE004_5030, 0, q);
      chk("unmapped", 32'h0000_0000, q);
      wb(1, UII_ADR_IIR, 32'h0000_0081, q); // Enable, trigger 8
      chk("fifo_en", 32'h1, {31'h0, fen});
      wb(1, UII_ADR_IER, 32'h0000_0001, q);
      rx.count <= 5'h07;
      wb(0, UII_ADR_IIR, 0, q);
      chk("id_below_trig", 32'h0000_00C1, q);
      rx.count <= 5'h08;
      wb(0, UII_ADR_IIR, 0, q);
      chk("id_rda", 32'h0000_00C4, q);
      chk("irq_rda", 32'h1, {31'h0, irq});
      wb(1, UII_ADR_IER, 32'h0000_0000, q);
      wb(0, UII_ADR_IIR, 0, q);
      chk("id_rda_masked", 32'h0000_00C1, q);
   endtask

   task automatic t_line_error;
      wb(1, UII_ADR_IER, 32'h0000_0005, q);
      // Parity error stands at the edge that takes the id read
      fork
         wb(0, UII_ADR_IIR, 0, q);
         begin
            @(posedge sys_clk);
            rx.err_evt <= 4'h2;
            @(posedge sys_clk);
            rx.err_evt <= 4'h0;
         end
      join
      chk("id_frozen", 32'h0000_00C4, q);
      wb(0, UII_ADR_IIR, 0, q);
      chk("id_err_first", 32'h0000_00C6, q);
      wb(0, UII_ADR_LSR, 0, q);
      chk("lsr_cause", 32'h0000_0004, q & 32'h0000_001E);
      wb(0, UII_ADR_IIR, 0, q);
      chk("id_after_lsr", 32'h0000_00C4, q);
      rx.count <= 5'h00;
   endtask

   task automatic t_char_timeout;
      int n;
      wb(1, UII_ADR_IIR, 32'h0000_00C1, q); // Trigger 14
      wb(1, UII_ADR_IER, 32'h0000_0001, q);
      rx.data <= 8'hA5;
      tick <= 1'b1;
      @(posedge sys_clk);
      rx.wr <= 1'b1;
      rx.count <= 5'h01;
      @(posedge sys_clk);
      rx.wr <= 1'b0;
      wait_irq(1'b1, 600, n);
      // Word length 5, trigger 14, one held: 264 + 105 ticks, then flag and line registers
      chk("tmo_cycles", 32'd371, n);
      wb(0, UII_ADR_IIR, 0, q);
      chk("id_cti", 32'h0000_00CC, q);
      wb(0, UII_ADR_DATA, 0, q);
      chk("rx_read", 32'h0000_00A5, q);
      chk("rx_strobe", 32'h1, {31'h0, rd_seen});
      wb(0, UII_ADR_IIR, 0, q);
      chk("id_cti_cleared", 32'h0000_00C1, q);
      rx.count <= 5'h00;
   endtask

   task automatic t_tx_empty;
      int n;
      wb(1, UII_ADR_IER, 32'h0000_0002, q);
      wait_irq(1'b1, 400, n);
      wb(0, UII_ADR_IIR, 0, q);
      chk("id_tx_empty_irq", 32'h0000_00C2, q);
      wb(0, UII_ADR_IIR, 0, q);
      chk("id_tx_empty_irq_read_clr", 32'h0000_00C1, q);
      tx_count <= 5'h01;
      repeat (3) @(posedge sys_clk);
      tx_count <= 5'h00;
      repeat (6) @(posedge sys_clk);
      chk("tx_empty_irq_delayed", 32'h0, {31'h0, irq});
      wait_irq(1'b1, 400, n);
      chk("tx_empty_irq_after_delay", 32'h1, {31'h0, irq});
      // 96 ticks after the empty edge plus three register stages, less six cycles waited
      chk("tx_empty_irq_delay_cycles", 32'd93, n);
      wb(1, UII_ADR_DATA, 32'h0000_005A, q);
      chk("tx_strobe", 32'h1, {31'h0, stb_seen});
      chk("tx_data", 32'h5A, {24'h0, dat_seen});
      wb(0, UII_ADR_IIR, 0, q);
      chk("id_tx_empty_irq_wr_clr", 32'h0000_00C1, q);
      tx_count <= 5'h02;
      repeat (3) @(posedge sys_clk);
      tx_count <= 5'h00;
      wait_irq(1'b1, 4, n);
      chk("tx_empty_irq_immediate", 32'h1, {31'h0, irq});
      // Flag one edge after the empty edge, request line one later
      chk("tx_empty_irq_fast_cycles", 32'd3, n);
      wb(1, UII_ADR_IER, 32'h0000_0000, q);
   endtask

   task automatic t_autobaud;
      for (int b = 8; b <= 9; b++) begin
         wb(1, UII_ADR_IER, 32'h0000_0300, q);
         @(posedge sys_clk);
         if (b == 8) ab_done <= 1'b1;
         else ab_tmo <= 1'b1;
         @(posedge sys_clk);
         ab_done <= 1'b0;
         ab_tmo <= 1'b0;
         wb(0, UII_ADR_IIR, 0, q);
         chk("ab_flag_set", 32'h1, {31'h0, q[b]});
         wb(0, UII_ADR_IIR, 0, q);
         chk("ab_flag_kept", 32'h1, {31'h0, q[b]});
         wb(1, UII_ADR_ACR, 32'h1 << b, q);
         wb(0, UII_ADR_IIR, 0, q);
         chk("ab_flag_clr", 32'h0000_00C1, q);
      end
   endtask

   // ---------------------------------------------
   // Verdict and main sequence
   // ---------------------------------------------
   task automatic summarize;
      if (fail_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected several hundred cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      summarize();
   end

   initial begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset_and_rx_data();
      t_line_error();
      t_char_timeout();
      t_tx_empty();
      t_autobaud();
      // Rises: data, data with error, time-out, empty, delayed empty, fast empty
      chk("irq_entries", 32'd6, entries);
      summarize();
   end
endmodule
